// ==== design/audio_input_port.sv ====
// audio_input_port: slave-only serial audio receiver with apb registers.
// assumes all audio clocks come from the outside party and are sampled
// by sys_clk_i at well above the master clock rate.
//
// Chosen here: the APB slave port.
module audio_input_port
   import audio_rx_pkg::*;
(
   // clock and reset
   input  wire logic                     sys_clk_i,
   input  wire logic                     reset_i,
   // apb slave
   input  wire logic                     psel_i,
   input  wire logic                     penable_i,
   input  wire logic                     pwrite_i,
   input  wire logic [7:0]               paddr_i,
   input  wire logic [31:0]              pwdata_i,
   output logic      [31:0]              prdata_o,
   output logic                          pready_o,
   output logic                          pslverr_o,
   // audio pins
   input  wire audio_rx_pkg::audio_pins_s pins_i,
   // sample stream and controls
   output audio_rx_pkg::sample_out_s     sample_o,
   output logic      [1:0]               deemph_sel_o,
   output logic      [11:0]              clock_ratio_o
);
   import audio_rx_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   audio_pins_s meta;
   audio_pins_s sync;
   audio_pins_s sync_d;

   always_ff @(posedge sys_clk_i) begin
      meta   <= pins_i;
      sync   <= meta;
      sync_d <= sync;
   end

   wire logic bclk_rise = sync.bit_clock & ~sync_d.bit_clock;
   wire logic mclk_rise = sync.input_master_clock &
                          ~sync_d.input_master_clock;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0]          misc_configuration;
   logic [SAMPLE_W-1:0] held [NUM_CH];

   wire logic [2:0] fmt   = misc_configuration[FMT_LSB +: FMT_W];
   wire logic [2:0] len   = misc_configuration[LEN_LSB +: LEN_W];
   wire logic       multi = (fmt == FMT_OL1) | (fmt == FMT_OL2) |
                            (fmt == FMT_TDM);

   wire logic wr_en = psel_i & penable_i & pwrite_i;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         misc_configuration <= MISC_RESET;
      end else if (wr_en && paddr_i == OFS_MISC_CONFIGURATION) begin
         misc_configuration <= pwdata_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         deemph_sel_o <= DEEMP_OFF;
      end else begin
         deemph_sel_o <= misc_configuration[DEEMP_LSB +: DEEMP_W];
      end
   end

   // ---------------------------------------------------------------
   // auto rate detect: master clock edges per frame
   // ---------------------------------------------------------------
   logic [11:0] mclk_count;
   logic        ratio_low;
   wire logic   frame_rise = sync.frame_clock & ~sync_d.frame_clock;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         mclk_count    <= 12'h000;
         clock_ratio_o <= 12'h000;
         ratio_low     <= 1'b0;
      end else if (frame_rise) begin
         clock_ratio_o <= mclk_count;
         ratio_low     <= mclk_count < MIN_RATIO;
         // a master edge on the frame edge opens the new frame's count
         mclk_count    <= mclk_rise ? 12'h001 : 12'h000;
      end else if (mclk_rise && mclk_count != 12'hFFF) begin
         mclk_count <= mclk_count + 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // serial receive
   // ---------------------------------------------------------------
   logic                frame_prev;
   logic [8:0]          bit_pos;
   logic [5:0]          slot_bit;
   logic [2:0]          slot_idx;
   logic [SAMPLE_W-1:0] shift [NUM_LINE];
   // finished halves: the next half starts shifting on the same edge
   logic [SAMPLE_W-1:0] done_sh [NUM_LINE];
   logic [5:0]          slot_w;
   logic [5:0]          len_bits;
   logic [5:0]          rj_start;

   always_comb begin
      unique case (fmt)
         FMT_OL1: slot_w = SLOT_OL1;
         FMT_OL2: slot_w = SLOT_OL2;
         default: slot_w = SLOT_TDM;
      endcase
      unique case (len)
         LEN_18:  len_bits = 6'h12;
         LEN_20:  len_bits = 6'h14;
         LEN_24:  len_bits = 6'h18;
         LEN_32:  len_bits = 6'h20;
         default: len_bits = 6'h10;
      endcase
   end

   // frame edge seen at the bit clock rising edge
   wire logic fedge = sync.frame_clock != frame_prev;
   // i2s delays the msb by one bit clock
   wire logic [8:0] pos_now = fedge ? 9'h000 : bit_pos + 9'h001;
   wire logic [8:0] data_pos = (fmt == FMT_I2S) ? pos_now - 9'h001 : pos_now;

   // left side: i2s low, lj/rj high
   wire logic left_now = (fmt == FMT_I2S) ? ~frame_prev : frame_prev;

   // in lj, i2s and rj each frame clock edge closes a stereo half
   logic emit_pair;
   logic emit_left;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         frame_prev <= 1'b0;
         bit_pos    <= 9'h000;
         slot_bit   <= 6'h00;
         slot_idx   <= 3'h0;
         emit_pair  <= 1'b0;
         emit_left  <= 1'b0;
         for (int i = 0; i < NUM_LINE; i++) begin
            shift[i]   <= '0;
            done_sh[i] <= '0;
         end
      end else begin
         emit_pair <= 1'b0;
         if (bclk_rise) begin
            frame_prev <= sync.frame_clock;
            bit_pos    <= pos_now;
            if (!multi) begin
               if (fedge) begin
                  emit_pair <= 1'b1;
                  emit_left <= left_now;
                  for (int i = 0; i < NUM_LINE; i++) begin
                     done_sh[i] <= shift[i];
                  end
               end
               if (fmt == FMT_RJ) begin
                  // keep the last bits before the edge
                  for (int i = 0; i < NUM_LINE; i++) begin
                     shift[i] <= fedge ? {31'h0, sync.serial_data[i]} :
                        {shift[i][SAMPLE_W-2:0], sync.serial_data[i]};
                  end
               end else if (data_pos < {3'h0, len_bits} &&
                            !(fmt == FMT_I2S && fedge)) begin
                  // msb first into the top
                  for (int i = 0; i < NUM_LINE; i++) begin
                     shift[i][SAMPLE_W-1 - data_pos[4:0]] <=
                        sync.serial_data[i];
                  end
               end else if (fmt == FMT_I2S && fedge) begin
                  for (int i = 0; i < NUM_LINE; i++) begin
                     shift[i] <= '0;
                  end
               end
            end else begin
               // frame start resets the slot walk
               if (sync.frame_clock && !frame_prev) begin
                  slot_idx <= 3'h0;
                  if (fmt == FMT_TDM) begin
                     // tdm frame edge comes one bit ahead of the msb
                     slot_bit <= 6'h00;
                  end else begin
                     slot_bit <= 6'h01;
                     shift[0] <= {sync.serial_data[0], 31'h0};
                  end
               end else if (slot_idx < 3'(NUM_CH)) begin
                  if (slot_bit < len_bits) begin
                     shift[0][SAMPLE_W-1 - slot_bit[4:0]] <=
                        sync.serial_data[0];
                  end
                  if (slot_bit + 6'h01 == slot_w) begin
                     slot_bit <= 6'h00;
                     slot_idx <= slot_idx + 3'h1;
                  end else begin
                     slot_bit <= slot_bit + 6'h01;
                  end
               end
            end
         end
      end
   end

   // slot completes on the last bit of its width
   wire logic slot_done = multi & bclk_rise & (slot_idx < 3'(NUM_CH)) &
                          ~(sync.frame_clock & ~frame_prev) &
                          (slot_bit + 6'h01 == slot_w);

   // a full-width sample ends on the edge that closes its slot
   logic [SAMPLE_W-1:0] slot_val;

   always_comb begin
      slot_val = shift[0];
      if (slot_bit < len_bits) begin
         slot_val[SAMPLE_W-1 - slot_bit[4:0]] = sync.serial_data[0];
      end
   end

   // ---------------------------------------------------------------
   // channel mapping and held samples
   // ---------------------------------------------------------------
   function automatic logic [SAMPLE_W-1:0] trim(
      input logic [SAMPLE_W-1:0] v, input logic [5:0] n);
      logic [SAMPLE_W-1:0] m;
      m = ~({SAMPLE_W{1'b1}} >> n);
      return v & m;
   endfunction

   // rj sample is right aligned; move it to the top
   function automatic logic [SAMPLE_W-1:0] align_rj(
      input logic [SAMPLE_W-1:0] v, input logic [2:0] l);
      return (l == LEN_24) ? {v[23:0], 8'h00} : {v[15:0], 16'h0000};
   endfunction

   logic [2:0] emit_step;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         emit_step <= 3'h0;
         sample_o  <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            held[i] <= '0;
         end
      end else begin
         sample_o.valid <= 1'b0;
         if (slot_done) begin
            held[slot_idx] <= trim(slot_val, len_bits);
            sample_o.sample  <= trim(slot_val, len_bits);
            sample_o.channel <= slot_idx;
            sample_o.valid   <= 1'b1;
         end else if (emit_pair) begin
            emit_step <= 3'h1;
         end else if (emit_step != 3'h0) begin
            // line n goes to channel A_n or B_n
            held[{1'b0, emit_step[1:0]} - 3'h1 + (emit_left ? 3'h0 : 3'h3)]
               <= (fmt == FMT_RJ) ?
                  align_rj(done_sh[emit_step[1:0] - 2'h1], len) :
                  trim(done_sh[emit_step[1:0] - 2'h1], len_bits);
            sample_o.sample <= (fmt == FMT_RJ) ?
               align_rj(done_sh[emit_step[1:0] - 2'h1], len) :
               trim(done_sh[emit_step[1:0] - 2'h1], len_bits);
            sample_o.channel <= {1'b0, emit_step[1:0]} - 3'h1 +
                                (emit_left ? 3'h0 : 3'h3);
            sample_o.valid   <= 1'b1;
            emit_step <= (emit_step == 3'(NUM_LINE)) ? 3'h0 :
                         emit_step + 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // apb read side, zero wait states
   // ---------------------------------------------------------------
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;

   always_comb begin
      prdata_o = 32'h0000_0000;
      if (paddr_i == OFS_MISC_CONFIGURATION) begin
         prdata_o = {24'h00_0000, misc_configuration};
      end else if (paddr_i == OFS_RATE_STATUS) begin
         prdata_o = {19'h0_0000, ratio_low, clock_ratio_o};
      end else if (paddr_i >= OFS_SAMPLE_BASE &&
                   paddr_i < OFS_SAMPLE_BASE + 8'h18) begin
         prdata_o = held[3'((paddr_i - OFS_SAMPLE_BASE) >> 2)];
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_misc_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_MISC_CONFIGURATION |=>
      misc_configuration == $past(pwdata_i[7:0]))
      else $error("config write lost");
   a_deemph_follow: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) ##1 deemph_sel_o ==
      $past(misc_configuration[DEEMP_LSB +: DEEMP_W]))
      else $error("de-emphasis select stale");
   a_ratio_latch: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) frame_rise |=> clock_ratio_o ==
      $past(mclk_count))
      else $error("ratio not captured");
   a_multi_channel: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) multi && sample_o.valid |->
      sample_o.channel < 3'(NUM_CH))
      else $error("slot index out of range");
   a_slot_order: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) slot_done |=>
      slot_idx == $past(slot_idx) + 3'h1)
      else $error("slot order broken");
   a_slot_trim: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) slot_done |=> (sample_o.sample &
      ({SAMPLE_W{1'b1}} >> $past(len_bits))) == '0)
      else $error("bits past length kept");
   a_pair_emit: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) emit_pair && !slot_done |=>
      ##[1:2] sample_o.valid)
      else $error("stereo half not emitted");
   a_slot_width: assert property (@(posedge sys_clk_i)
      disable iff (reset_i) multi |-> slot_bit < slot_w)
      else $error("slot counter past width");
   c_i2s_pair:  cover property (@(posedge sys_clk_i)
      fmt == FMT_I2S && emit_pair);
   c_rj_pair:   cover property (@(posedge sys_clk_i)
      fmt == FMT_RJ && emit_pair);
   c_tdm_last:  cover property (@(posedge sys_clk_i)
      fmt == FMT_TDM && slot_done && slot_idx == 3'h5);
endmodule

// ==== shared/audio_rx_pkg.sv ====
// audio_rx_pkg: constants, register map and carrier types for the
// six-channel audio serial receiver.
// assumes a 32-bit apb register bus and one system clock.
package audio_rx_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_MISC_CONFIGURATION = 8'h04;
   localparam logic [7:0] OFS_RATE_STATUS        = 8'h08;
   localparam logic [7:0] OFS_SAMPLE_BASE        = 8'h10;
   localparam logic [7:0] MISC_RESET             = 8'h00;

   // misc_configuration fields
   localparam int FMT_LSB   = 0;
   localparam int FMT_W     = 3;
   localparam int LEN_LSB   = 3;
   localparam int LEN_W     = 3;
   localparam int DEEMP_LSB = 6;
   localparam int DEEMP_W   = 2;

   // ---------------------------------------------------------------
   // framing formats and sample lengths
   // ---------------------------------------------------------------
   localparam logic [2:0] FMT_LJ   = 3'h0;
   localparam logic [2:0] FMT_I2S  = 3'h1;
   localparam logic [2:0] FMT_RJ   = 3'h2;
   localparam logic [2:0] FMT_OL1  = 3'h3;
   localparam logic [2:0] FMT_OL2  = 3'h4;
   localparam logic [2:0] FMT_TDM  = 3'h5;

   localparam logic [2:0] LEN_16 = 3'h0;
   localparam logic [2:0] LEN_18 = 3'h1;
   localparam logic [2:0] LEN_20 = 3'h2;
   localparam logic [2:0] LEN_24 = 3'h3;
   localparam logic [2:0] LEN_32 = 3'h4;

   localparam logic [5:0] SLOT_OL1 = 6'h14;
   localparam logic [5:0] SLOT_OL2 = 6'h18;
   localparam logic [5:0] SLOT_TDM = 6'h20;
   localparam int         NUM_CH   = 6;
   localparam int         NUM_LINE = 3;
   localparam int         SAMPLE_W = 32;

   // de-emphasis selection codes
   localparam logic [1:0] DEEMP_OFF = 2'h0;
   localparam logic [1:0] DEEMP_32K = 2'h1;
   localparam logic [1:0] DEEMP_44K = 2'h2;
   localparam logic [1:0] DEEMP_48K = 2'h3;

   // rate detect: master clock edges per frame, least ratio allowed
   localparam logic [11:0] MIN_RATIO = 12'h080;

   typedef struct packed {
      logic       frame_clock;
      logic       bit_clock;
      logic       input_master_clock;
      logic [2:0] serial_data;
   } audio_pins_s;

   typedef struct packed {
      logic [SAMPLE_W-1:0] sample;
      logic [2:0]          channel;
      logic                valid;
   } sample_out_s;

endpackage

// ==== verification/audio_sender.sv ====
// audio_sender: behavioural audio processor driving the receiver pins.
// assumes the bench reads exp_q, last_s, nb and armed after each run.
module audio_sender
   import audio_rx_pkg::*;
(
   // pins toward the receiver
   output audio_rx_pkg::audio_pins_s pins_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [34:0] exp_q[$];
   logic [31:0] last_s[6];
   logic        armed;
   int          nb;

   initial begin
      pins_o = '0;
      armed  = 1'b0;
   end

   // -----------------------------------------------------------------
   // one bit period
   // -----------------------------------------------------------------
   // two master periods per bit keep all clocks locked
   task automatic put_bit(input logic fr, input logic [2:0] d);
      pins_o.frame_clock        = fr;
      pins_o.serial_data        = d;
      pins_o.bit_clock          = 1'b0;
      pins_o.input_master_clock = 1'b1;
      #22 pins_o.input_master_clock = 1'b0;
      #22 pins_o.bit_clock = 1'b1;
      pins_o.input_master_clock = 1'b1;
      #22 pins_o.input_master_clock = 1'b0;
      #22;
   endtask

   // -----------------------------------------------------------------
   // one unchecked frame, one checked frame, then the closing edge
   // -----------------------------------------------------------------
   // 88 ns bits keep the 128- and 256-bit frames under 96 kHz; the 64-bit modes run near 178 kHz
   task automatic run(input logic [2:0] fmt, input int len);
      logic [2:0]  dat[256];
      logic        fr[256];
      logic [31:0] smp;
      logic        multi;
      int          el, w, pos, ln;
      multi = (fmt >= FMT_OL1);
      nb    = (fmt == FMT_OL1) ? 128 : (multi ? 256 : 64);
      w     = (fmt == FMT_OL1) ? 20 : ((fmt == FMT_OL2) ? 24 : 32);
      el    = (fmt == FMT_RJ && len != 24) ? 16 : len;
      for (int f = 0; f < 2; f++) begin
         for (int k = 0; k < nb; k++) begin
            dat[k] = 3'($urandom);
            // frame high for half a frame
            fr[k]  = (k < nb / 2) ^ (fmt == FMT_I2S);
         end
         for (int ch = 0; ch < 6; ch++) begin
            smp = $urandom & ~(32'hFFFF_FFFF >> el);
            ln  = multi ? 0 : ch % 3;
            pos = multi ? ch * w : (ch / 3) * 32;
            // i2s and tdm put the msb one bit after the frame edge
            if (fmt == FMT_I2S || fmt == FMT_TDM)
               pos++;
            if (fmt == FMT_RJ)
               pos += 32 - el;
            for (int b = 0; b < el; b++)
               dat[pos + b][ln] = smp[31 - b];
            if (f == 1) begin
               exp_q.push_back({3'(ch), smp});
               last_s[ch] = smp;
            end
         end
         for (int k = 0; k < nb; k++) begin
            put_bit(fr[k], dat[k]);
            if (f == 1 && k == 0)
               armed = 1'b1;
         end
      end
      put_bit(fr[0], ~dat[nb - 1]);
      // clocks stand still and data shows the inverse of the frame's first bits
      pins_o.bit_clock   = 1'b0;
      pins_o.serial_data = ~dat[0];
      #400 armed = 1'b0;
   endtask
endmodule

// ==== verification/six_channel_audio_serial_input_tb.sv ====
// six_channel_audio_serial_input_tb: apb and serial stimulus, scoreboard.
// assumes the sender model pushes the samples it sends into exp_q.
module six_channel_audio_serial_input_tb
   import audio_rx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [2:0] T_FMT [12] = '{FMT_LJ, FMT_LJ, FMT_I2S, FMT_I2S,
      FMT_RJ, FMT_RJ, FMT_OL1, FMT_OL1, FMT_OL2, FMT_OL2, FMT_TDM, FMT_TDM};
   localparam logic [2:0] T_CODE [12] = '{LEN_16, LEN_24, LEN_18, LEN_24,
      LEN_16, LEN_24, LEN_16, LEN_20, LEN_18, LEN_24, LEN_20, LEN_32};
   localparam int         T_LEN [12] = '{16, 24, 18, 24, 16, 24, 16, 20,
      18, 24, 20, 32};

   logic        sys_clk_i;
   logic        reset_i;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   audio_pins_s pins;
   sample_out_s smp_o;
   logic [1:0]  deemph;
   logic [11:0] ratio;
   logic [31:0] rd;
   logic [34:0] e;
   int          err_total;
   int          total_checks;

   always #2.5 sys_clk_i = ~sys_clk_i;

   audio_input_port i_dut (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pins_i(pins), .sample_o(smp_o),
      .deemph_sel_o(deemph), .clock_ratio_o(ratio)
   );

   audio_sender i_send (.pins_o(pins));

   // -----------------------------------------------------------------
   // checking and closing
   // -----------------------------------------------------------------
   task automatic chk_val(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (err_total == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // apb master: holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) begin
         err_total++;
         wrap_up();
      end
      rd = prdata;
      chk_val("pslverr", 32'h0, 32'(pslverr));
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge sys_clk_i) begin
      if (i_send.armed && smp_o.valid === 1'b1) begin
         if (i_send.exp_q.size() == 0) begin
            chk_val("extra sample", 32'h0, 32'h1);
         end else begin
            e = i_send.exp_q.pop_front();
            chk_val("channel", 32'(e[34:32]), 32'(smp_o.channel));
            chk_val("sample", e[31:0], smp_o.sample);
         end
      end
   end

   initial begin
      #480_000;
      err_total++;
      wrap_up();
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      sys_clk_i    = 1'b0;
      reset_i      = 1'b1;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      paddr        = 8'h00;
      pwdata       = 32'h0;
      rd           = 32'h0;
      err_total    = 0;
      total_checks = 0;
      void'($urandom(32'hAF5D));
      repeat (5) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      apb(1'b0, OFS_MISC_CONFIGURATION, 32'h0);
      chk_val("misc reset", {24'h0, MISC_RESET}, rd);
      apb(1'b1, 8'h40, $urandom);
      apb(1'b0, 8'h40, 32'h0);
      chk_val("unmapped", 32'h0, rd);
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, OFS_MISC_CONFIGURATION, {24'h0, 2'(d), LEN_16, FMT_LJ});
         apb(1'b0, OFS_MISC_CONFIGURATION, 32'h0);
         chk_val("misc", {24'h0, 2'(d), LEN_16, FMT_LJ}, rd);
         repeat (3) @(posedge sys_clk_i);
         chk_val("deemphasis", 32'(d), 32'(deemph));
      end
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, OFS_MISC_CONFIGURATION,
             {24'h0, DEEMP_OFF, T_CODE[i], T_FMT[i]});
         i_send.run(T_FMT[i], T_LEN[i]);
         chk_val("missing", 32'h0, 32'(i_send.exp_q.size()));
         chk_val("ratio", 32'(2 * i_send.nb), 32'(ratio));
         // status is read-only: the write must leave it untouched
         apb(1'b1, OFS_RATE_STATUS, 32'hFFFF_FFFF);
         apb(1'b0, OFS_RATE_STATUS, 32'h0);
         chk_val("status", 32'(2 * i_send.nb), rd);
         for (int ch = 0; ch < 6; ch++) begin
            apb(1'b0, OFS_SAMPLE_BASE + 8'(4 * ch), 32'h0);
            chk_val("held sample", i_send.last_s[ch], rd);
         end
      end
      wrap_up();
   end
endmodule
